// ### hdl/mdevm_event_mask.sv
`timescale 1ns/10ps

module mdevm_event_mask
    import mdevm_pkg::*;
#(
    parameter int PHYS = 32
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    input  wire logic [PHYS-1:0]      link_state,
    input  wire logic [1:0]           user_cmd_done,
    output logic                      user_cmd_irq,
    output logic                      link_change_irq,
    output logic                      irq
);
    initial begin
        if (PHYS < 1 || PHYS > (1 << PHY_ADDR_W))
            $error("mdevm_event_mask: PHYS out of range");
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    mdevm_bus_req_type req;
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    logic [1:0] wbits;
    assign wbits = req.wdata[1:0];  // Upper bits are dropped here.

    logic wr_ctrl, wr_lraw, wr_lmask, wr_uraw, wr_umask;
    logic wr_eset, wr_eclr, wr_sel0, wr_sel1, wr_ien, wr_iclr;
    assign wr_ctrl  = req.wr && req.addr == REG_CONTROL;
    assign wr_lraw  = req.wr && req.addr == REG_LINK_RAW;
    assign wr_lmask = req.wr && req.addr == REG_LINK_MASKED;
    assign wr_uraw  = req.wr && req.addr == REG_USER_RAW;
    assign wr_umask = req.wr && req.addr == REG_USER_MASKED;
    assign wr_eset  = req.wr && req.addr == REG_USER_ENABLE_SET;
    assign wr_eclr  = req.wr && req.addr == REG_USER_ENABLE_CLR;
    assign wr_sel0  = req.wr && req.addr == REG_MONITOR_SEL_0;
    assign wr_sel1  = req.wr && req.addr == REG_MONITOR_SEL_1;
    assign wr_ien   = req.wr && req.addr == REG_IRQ_ENABLE;
    assign wr_iclr  = req.wr && req.addr == REG_IRQ_CLEAR;

    // ------------------------------------------------------------------
    // Control and monitor select
    // ------------------------------------------------------------------
    logic              test_en_q;
    mdevm_monitor_type mon_q [NUM_CHANNELS];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            test_en_q <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
            test_en_q <= req.wdata[TEST_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mon_q[0] <= '0;
            mon_q[1] <= '0;
        end else if (clk_en) begin
            if (wr_sel0) begin
                mon_q[0] <= '{req.wdata[LINK_INT_EN_BIT],
                              req.wdata[PHY_ADDR_LSB +: PHY_ADDR_W]};
            end
            if (wr_sel1) begin
                mon_q[1] <= '{req.wdata[LINK_INT_EN_BIT],
                              req.wdata[PHY_ADDR_LSB +: PHY_ADDR_W]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-channel event and mask bits
    // ------------------------------------------------------------------
    logic [1:0] link_raw_q, link_mask_q, user_raw_q, user_mask_q, user_en_q;
    logic [1:0] link_chg;
    logic [1:0] test_set_lraw, test_set_lmask, test_set_uraw, test_set_umask;

    // Test writes only set bits; a write of 1 without test enable clears instead.
    assign test_set_lraw  = (wr_lraw  && test_en_q) ? wbits : 2'b00;
    assign test_set_lmask = (wr_lmask && test_en_q) ? wbits : 2'b00;
    assign test_set_uraw  = (wr_uraw  && test_en_q) ? wbits : 2'b00;
    assign test_set_umask = (wr_umask && test_en_q) ? wbits : 2'b00;

    generate
        for (genvar n = 0; n < NUM_CHANNELS; n++) begin : g_ch
            mdevm_link_watch #(
                .PHYS (PHYS)
            ) u_watch (
                .clk        (clk),
                .reset      (reset),
                .clk_en     (clk_en),
                .link_state (link_state),
                .watch_addr (mon_q[n].monitored_phy_address),
                .changed    (link_chg[n])
            );

            // Hardware or test set wins over a clear in the same cycle.
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    link_raw_q[n] <= 1'b0;
                end else if (clk_en) begin
                    if (link_chg[n] || test_set_lraw[n])
                        link_raw_q[n] <= 1'b1;
                    else if (wr_lraw && !test_en_q && wbits[n])
                        link_raw_q[n] <= 1'b0;
                end
            end

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    link_mask_q[n] <= 1'b0;
                end else if (clk_en) begin
                    if ((link_chg[n] && mon_q[n].link_interrupt_enable)
                        || test_set_lmask[n])
                        link_mask_q[n] <= 1'b1;
                    else if (wr_lmask && !test_en_q && wbits[n])
                        link_mask_q[n] <= 1'b0;
                end
            end

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    user_raw_q[n] <= 1'b0;
                end else if (clk_en) begin
                    if (user_cmd_done[n] || test_set_uraw[n])
                        user_raw_q[n] <= 1'b1;
                    else if (wr_uraw && !test_en_q && wbits[n])
                        user_raw_q[n] <= 1'b0;
                end
            end

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    user_mask_q[n] <= 1'b0;
                end else if (clk_en) begin
                    if ((user_cmd_done[n] && user_en_q[n]) || test_set_umask[n])
                        user_mask_q[n] <= 1'b1;
                    else if (wr_umask && !test_en_q && wbits[n])
                        user_mask_q[n] <= 1'b0;
                end
            end

            // Set wins over clear if both registers are written in one cycle;
            // they share no address, so one bus write can never do that.
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    user_en_q[n] <= 1'b0;
                end else if (clk_en) begin
                    if (wr_eset && wbits[n])
                        user_en_q[n] <= 1'b1;
                    else if (wr_eclr && wbits[n])
                        user_en_q[n] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Interrupt outputs and the combined interrupt status
    // ------------------------------------------------------------------
    logic [IRQ_SRC_W-1:0] irq_stat_q, irq_en_q, irq_src;
    assign irq_src[IRQ_USER_BIT] = |user_mask_q;
    assign irq_src[IRQ_LINK_BIT] = |link_mask_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= '0;
        end else if (clk_en) begin
            // A new event beats a clear landing in the same cycle.
            irq_stat_q <= irq_src | (irq_stat_q & ~(wr_iclr ? wbits : 2'b00));
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_en_q <= '0;
        end else if (clk_en && wr_ien) begin
            irq_en_q <= wbits;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            user_cmd_irq    <= 1'b0;
            link_change_irq <= 1'b0;
            irq             <= 1'b0;
        end else if (clk_en) begin
            user_cmd_irq    <= irq_src[IRQ_USER_BIT];
            link_change_irq <= irq_src[IRQ_LINK_BIT];
            irq             <= |(irq_stat_q & irq_en_q);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = RESET_WORD;
        unique case (req.addr)
            REG_CONTROL:         rdata_d[TEST_ENABLE_BIT] = test_en_q;
            REG_LINK_RAW:        rdata_d[1:0] = link_raw_q;
            REG_LINK_MASKED:     rdata_d[1:0] = link_mask_q;
            REG_USER_RAW:        rdata_d[1:0] = user_raw_q;
            REG_USER_MASKED:     rdata_d[1:0] = user_mask_q;
            REG_USER_ENABLE_SET: rdata_d[1:0] = user_en_q;
            REG_USER_ENABLE_CLR: rdata_d[1:0] = user_en_q;
            REG_MONITOR_SEL_0: begin
                rdata_d[LINK_INT_EN_BIT] = mon_q[0].link_interrupt_enable;
                rdata_d[PHY_ADDR_LSB +: PHY_ADDR_W] = mon_q[0].monitored_phy_address;
            end
            REG_MONITOR_SEL_1: begin
                rdata_d[LINK_INT_EN_BIT] = mon_q[1].link_interrupt_enable;
                rdata_d[PHY_ADDR_LSB +: PHY_ADDR_W] = mon_q[1].monitored_phy_address;
            end
            REG_IRQ_STATUS:      rdata_d[1:0] = irq_stat_q;
            REG_IRQ_ENABLE:      rdata_d[1:0] = irq_en_q;
            default:             rdata_d = RESET_WORD;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= RESET_WORD;
        end else if (clk_en) begin
            reg_rdata <= req.rd ? rdata_d : RESET_WORD;
        end
    end
endmodule

// ### hdl/mdevm_pkg.sv
package mdevm_pkg;

    // ------------------------------------------------------------------
    // Register map (word indices of the local register port)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;

    localparam logic [3:0] REG_CONTROL          = 4'h0;
    localparam logic [3:0] REG_LINK_RAW         = 4'h1;
    localparam logic [3:0] REG_LINK_MASKED      = 4'h2;
    localparam logic [3:0] REG_USER_RAW         = 4'h3;
    localparam logic [3:0] REG_USER_MASKED      = 4'h4;
    localparam logic [3:0] REG_USER_ENABLE_SET  = 4'h5;
    localparam logic [3:0] REG_USER_ENABLE_CLR  = 4'h6;
    localparam logic [3:0] REG_MONITOR_SEL_0    = 4'h7;
    localparam logic [3:0] REG_MONITOR_SEL_1    = 4'h8;
    localparam logic [3:0] REG_IRQ_STATUS       = 4'h9;
    localparam logic [3:0] REG_IRQ_ENABLE       = 4'ha;
    localparam logic [3:0] REG_IRQ_CLEAR        = 4'hb;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TEST_ENABLE_BIT  = 17;
    localparam int LINK_INT_EN_BIT  = 6;
    localparam int PHY_ADDR_LSB     = 0;
    localparam int PHY_ADDR_W       = 5;
    localparam int NUM_CHANNELS     = 2;
    localparam int IRQ_SRC_W        = 2;
    localparam int IRQ_USER_BIT     = 0;
    localparam int IRQ_LINK_BIT     = 1;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        link_interrupt_enable;
        logic [4:0]  monitored_phy_address;
    } mdevm_monitor_type;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } mdevm_bus_req_type;

endpackage

// ### hdl/mdevm_link_watch.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Watches the link status bit of one monitored PHY address.
// ----------------------------------------------------------------------
// A change of the watched address is not itself an event: the reference
// value is reloaded so that a reprogrammed monitor does not fire falsely.
module mdevm_link_watch
    import mdevm_pkg::*;
#(
    parameter int PHYS = 32
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire logic [PHYS-1:0]       link_state,
    input  wire logic [PHY_ADDR_W-1:0] watch_addr,
    output logic                       changed
);
    initial begin
        if (PHYS < 1 || PHYS > (1 << PHY_ADDR_W))
            $error("mdevm_link_watch: PHYS out of range");
    end

    logic                  seen_q;
    logic [PHY_ADDR_W-1:0] addr_q;
    logic                  cur;

    assign cur     = link_state[watch_addr];
    assign changed = (addr_q == watch_addr) && (cur != seen_q);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            seen_q <= 1'b0;
            addr_q <= '0;
        end else if (clk_en) begin
            seen_q <= cur;
            addr_q <= watch_addr;
        end
    end
endmodule

// ### tb/mdevm_event_mask_checker.sv
`timescale 1ns/10ps

module mdevm_event_mask_checker
    import mdevm_pkg::*;
#(
    parameter int PHYS = 32
) (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic [PHYS-1:0]   link_state,
    input wire logic [1:0]        user_cmd_done,
    input wire logic              user_cmd_irq,
    input wire logic              link_change_irq,
    input wire logic              irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_read_stands: assert property (
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    a_status_upper: assert property (
        $past(reg_rd) && $past(reg_addr) inside {[REG_LINK_RAW:REG_USER_ENABLE_CLR]}
        |-> reg_rdata[31:2] == 30'h0)
        else $error("upper status bits not zero");
    a_unmapped_zero: assert property (
        $past(reg_rd) && $past(reg_addr) >= REG_IRQ_CLEAR
        |-> reg_rdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    a_raw_done_seen: assert property (
        user_cmd_done != 2'h0 ##2 reg_rd && reg_addr == REG_USER_RAW
        |=> (reg_rdata[1:0] & $past(user_cmd_done, 3)) == $past(user_cmd_done, 3))
        else $error("completion missing from raw bits");
    a_user_irq_rise: assert property (
        $rose(user_cmd_irq) |-> $past(user_cmd_done, 2) != 2'h0
        || ($past(reg_wr, 2) && $past(reg_addr, 2) == REG_USER_MASKED))
        else $error("user interrupt rose without cause");
    a_user_irq_fall: assert property (
        $fell(user_cmd_irq)
        |-> $past(reg_wr, 2) && $past(reg_addr, 2) == REG_USER_MASKED)
        else $error("user interrupt fell without clear");
    a_link_irq_fall: assert property (
        $fell(link_change_irq)
        |-> $past(reg_wr, 2) && $past(reg_addr, 2) == REG_LINK_MASKED)
        else $error("link interrupt fell without clear");
    a_irq_fall: assert property (
        $fell(irq) |-> $past(reg_wr, 2)
        && ($past(reg_addr, 2) == REG_IRQ_ENABLE || $past(reg_addr, 2) == REG_IRQ_CLEAR))
        else $error("interrupt output fell without clear or mask");
    a_reset_quiet: assert property (
        $fell(reset) |-> !irq && !user_cmd_irq
        && !link_change_irq && reg_rdata == 32'h0)
        else $error("outputs not quiet after reset");

    cover property (user_cmd_done != 2'h0 ##1 user_cmd_irq);
    cover property ($rose(link_change_irq));
    cover property ($rose(irq));
    cover property (!clk_en && user_cmd_done != 2'h0);
endmodule

bind mdevm_event_mask mdevm_event_mask_checker #(.PHYS(PHYS)) u_chk (
    .clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_state(link_state), .user_cmd_done(user_cmd_done),
    .user_cmd_irq(user_cmd_irq), .link_change_irq(link_change_irq), .irq(irq));

// ### tb/tb_top.sv
`timescale 1ns/10ps

module tb_top;
    import mdevm_pkg::*;
    logic        clk, reset, clk_en, reg_wr, reg_rd, user_cmd_irq, link_change_irq, irq;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, link_state;
    logic [1:0]  user_cmd_done;
    int          fail_count, comparisons;

    mdevm_event_mask #(.PHYS(32)) DUT (
        .clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link_state(link_state), .user_cmd_done(user_cmd_done),
        .user_cmd_irq(user_cmd_irq), .link_change_irq(link_change_irq), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("register %0d", a), exp, reg_rdata);
    endtask

    task automatic pulse(input logic [1:0] b);
        @(posedge clk);
        user_cmd_done <= b;
        @(posedge clk);
        user_cmd_done <= 2'h0;
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        results();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata, link_state, user_cmd_done} = '0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 16; a++) rd(a[3:0], 32'h0);
        pulse(2'h1);
        rd(REG_USER_RAW, 32'h1);
        rd(REG_USER_MASKED, 32'h0);
        wr(REG_USER_RAW, 32'hffff_fffe);
        rd(REG_USER_RAW, 32'h1);
        wr(REG_USER_RAW, 32'h1);
        rd(REG_USER_RAW, 32'h0);
        wr(REG_USER_ENABLE_SET, 32'hffff_fffe);
        rd(REG_USER_ENABLE_SET, 32'h2);
        wr(REG_USER_ENABLE_SET, 32'h1);
        wr(REG_USER_ENABLE_CLR, 32'h2);
        rd(REG_USER_ENABLE_CLR, 32'h1);
        pulse(2'h3);
        rd(REG_USER_RAW, 32'h3);
        rd(REG_USER_MASKED, 32'h1);
        chk("user_cmd_irq", 32'h1, 32'(user_cmd_irq));
        chk("irq", 32'h0, 32'(irq));
        wr(REG_IRQ_ENABLE, 32'h1);
        rd(REG_IRQ_STATUS, 32'h1);
        rd(REG_IRQ_ENABLE, 32'h1);
        chk("irq", 32'h1, 32'(irq));
        wr(REG_USER_MASKED, 32'h0);
        rd(REG_USER_MASKED, 32'h1);
        wr(REG_USER_MASKED, 32'h1);
        wr(REG_IRQ_CLEAR, 32'h1);
        rd(REG_IRQ_STATUS, 32'h0);
        chk("irq", 32'h0, 32'(irq) | 32'(user_cmd_irq));
        wr(REG_USER_RAW, 32'h3);
        wr(REG_USER_ENABLE_CLR, 32'h3);
        wr(REG_LINK_MASKED, 32'h1);
        rd(REG_LINK_MASKED, 32'h0);
        wr(REG_CONTROL, 32'hffff_ffff);
        rd(REG_CONTROL, 32'h0002_0000);
        wr(REG_LINK_MASKED, 32'h3);
        rd(REG_LINK_MASKED, 32'h3);
        wr(REG_USER_RAW, 32'h2);
        rd(REG_USER_RAW, 32'h2);
        chk("link_change_irq", 32'h1, 32'(link_change_irq));
        wr(REG_CONTROL, 32'h0);
        wr(REG_LINK_MASKED, 32'h1);
        rd(REG_LINK_MASKED, 32'h2);
        wr(REG_LINK_MASKED, 32'h2);
        rd(REG_LINK_MASKED, 32'h0);
        wr(REG_USER_RAW, 32'h2);
        wr(REG_IRQ_CLEAR, 32'h3);
        wr(REG_MONITOR_SEL_0, 32'h45);
        wr(REG_MONITOR_SEL_1, 32'h0a);
        rd(REG_MONITOR_SEL_0, 32'h45);
        @(posedge clk);
        link_state <= 32'h20;
        for (int i = 0; i < 20 && link_change_irq !== 1'b1; i++) @(posedge clk);
        chk("link_change_irq", 32'h1, 32'(link_change_irq));
        if (link_change_irq !== 1'b1) results();
        rd(REG_IRQ_STATUS, 32'h2);
        chk("irq", 32'h0, 32'(irq));
        @(posedge clk);
        link_state <= 32'h420;
        rd(REG_LINK_MASKED, 32'h1);
        rd(REG_LINK_RAW, 32'h3);
        wr(REG_LINK_MASKED, 32'h1);
        wr(REG_LINK_RAW, 32'h3);
        rd(REG_LINK_RAW, 32'h0);
        chk("link_change_irq", 32'h0, 32'(link_change_irq));
        // A completion that arrives while the clock enable is low must be lost.
        @(posedge clk);
        clk_en <= 1'b0;
        pulse(2'h3);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(REG_USER_RAW, 32'h0);
        chk("user_cmd_irq", 32'h0, 32'(user_cmd_irq));
        results();
    end
endmodule
